// ===== verilog/ump_pkg.sv
// constants and carrier types of the multi-processor serial port
// assumes a single system clock and an apb3 register slave
package ump_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] UMP_ADDR_CTRL_STATUS_A = 8'hc0;
	localparam logic [7:0] UMP_ADDR_DATA_BUFFER = 8'hc4;
	localparam logic [7:0] UMP_ADDR_CTRL_B = 8'hc8;
	localparam logic [7:0] UMP_ADDR_BAUD = 8'hcc;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int UMP_BIT_RXC = 7;
	localparam int UMP_BIT_TXC = 6;
	localparam int UMP_BIT_DOUBLE = 1;
	localparam int UMP_BIT_FILTER = 0;
	localparam int UMP_BIT_RXEN = 0;
	localparam int UMP_BIT_TXEN = 1;
	localparam int UMP_POS_CSIZE = 2;
	localparam int UMP_POS_PARITY = 5;
	localparam int UMP_BIT_STOP2 = 7;
	localparam int UMP_BIT_RX9 = 8;
	localparam int UMP_BIT_TX9 = 9;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [7:0] UMP_RST_CTRL_STATUS_A = 8'h20;
	localparam logic [2:0] UMP_RST_CSIZE = 3'h3;
	localparam logic [2:0] UMP_CSIZE_NINE = 3'h7;
	localparam int UMP_DIV_W = 12;
	localparam logic [11:0] UMP_RST_DIVISOR = 12'h000;

	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam logic [4:0] UMP_SAMPLES_NORMAL = 5'h10;
	localparam logic [4:0] UMP_SAMPLES_DOUBLE = 5'h08;
	localparam logic [4:0] UMP_VOTE_NORMAL = 5'h08;
	localparam logic [4:0] UMP_VOTE_DOUBLE = 5'h04;
	localparam int UMP_RX_DEPTH = 2;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
		logic frameErr;
		logic parityErr;
	} ump_rx_entry_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} ump_rx_state_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} ump_tx_state_t;

endpackage

// ===== verilog/ump_rx_fifo.sv
// small receive fifo, read data held in a register
// assumes push only when not full; pop on empty is ignored
`timescale 1ns/100ps
module ump_rx_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [WIDTH-1:0] pushData,
	input wire logic pop,
	output logic [WIDTH-1:0] headData,
	output logic headValid,
	output logic full
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CFULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic [CW-1:0] count;
	logic doPush;
	logic doPop;

	assign doPush = push && (count != CFULL);
	assign doPop = pop && (count != '0);
	assign full = (count == CFULL);

	always_ff @(posedge clk_sys) begin
		if (doPush) begin
			mem[wrPtr] <= pushData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doPush) begin
				wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + PW'(1);
			end
			if (doPop) begin
				rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + PW'(1);
			end
			count <= count + CW'(doPush) - CW'(doPop);
		end
	end

	// head follows the pointers one cycle later
	always_ff @(posedge clk_sys) begin
		if (!rst_n || flush) begin
			headData <= '0;
			headValid <= 1'b0;
		end else begin
			headData <= mem[rdPtr];
			headValid <= (count != '0);
		end
	end

endmodule

// ===== verilog/ump_baud_gen.sv
// baud divider: sample tick every divisor+1 clocks, bit tick every 16 or 8 samples
// assumes divisor is static while frames are in flight
`timescale 1ns/100ps
module ump_baud_gen import ump_pkg::*; #(
	parameter int DIV_W = UMP_DIV_W
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic doubleSpeed,
	output logic sampleTick,
	output logic bitTick
);
	logic [DIV_W-1:0] divCnt;
	logic [4:0] sampCnt;
	logic [4:0] perBit;

	assign perBit = doubleSpeed ? UMP_SAMPLES_DOUBLE : UMP_SAMPLES_NORMAL;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			divCnt <= '0;
			sampCnt <= '0;
			sampleTick <= 1'b0;
			bitTick <= 1'b0;
		end else begin
			sampleTick <= (divCnt == '0);
			bitTick <= 1'b0;
			if (divCnt == '0) begin
				divCnt <= divisor;
				if (sampCnt >= perBit - 5'h01) begin
					sampCnt <= '0;
					bitTick <= 1'b1;
				end else begin
					sampCnt <= sampCnt + 5'h01;
				end
			end else begin
				divCnt <= divCnt - DIV_W'(1);
			end
		end
	end

endmodule

// ===== verilog/ump_serial.sv
// multi-processor serial port: apb registers, transmitter, receiver, status flags
// assumes apb3 master on clk_sys; serial_in_pin is asynchronous
//
// What this block does
// - with the filter on, non-address frames are dropped before the receive buffer
// - for 5 to 8 data bits the first stop bit gives the frame type
// - for nine data bits the received ninth bit gives the frame type
// - frame type one means address frame, zero means data frame
// - the transmitter ignores the filter setting entirely
// - data location writes go to transmit holding, reads return receive holding
// - unused upper bits are ignored on transmit and read as zero on receive
// - data writes while the buffer-empty flag is clear are ignored
// - buffered data moves to the shifter when enabled and shifter empty
// - receive buffer is a two-entry fifo that advances on each data read
// - receive complete is set while unread data exists; receiver disable flushes
// - transmit complete sets after the last frame leaves; clears on ack or write one
// - buffer-empty flag is one when holding is free, and after reset
// - frame error reflects the head character's first stop bit being zero
// - overrun sets when fifo full, character waiting, and a new start arrives
// - parity error reflects head character mismatch when parity checking was on
// - double speed changes the samples per bit from 16 to 8
// - receive complete, transmit complete and buffer empty drive request outputs
// - disabling the receiver flushes the fifo and clears the error flags
`timescale 1ns/100ps
module ump_serial import ump_pkg::*; #(
	parameter int DIV_W = UMP_DIV_W
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic txCompleteAck,
	output logic rxCompleteReq,
	output logic txCompleteReq,
	output logic txEmptyReq
);
	// ----------------------------------------
	// helpers and state
	// ----------------------------------------
	function automatic logic [3:0] charBits(input logic [2:0] code);
		charBits = (code == UMP_CSIZE_NINE) ? 4'h9 : {2'b01, code[1:0]} + 4'h1;
	endfunction

	function automatic logic [8:0] charMask(input logic [2:0] code);
		logic [3:0] nb;
		nb = charBits(code);
		charMask = 9'(({9'h000, 1'b1} << nb) - 10'h001);
	endfunction

	logic rxMeta, rxSync, rxPrev, filterEn, doubleSpeed, rxEnable, txEnable, stopBitsSel;
	logic txNinth, sampleTick, bitTick, access, mapped, dataRead, dataWrite, ctrlWrite;
	logic headValid, fifoFull, fifoPush, waitValid, overrunFlag, txCompleteFlag, txBufFull;
	logic v0, v1, vote, parityOn, startSeen, stopDecide, frameType;
	logic [2:0] charSizeSel;
	logic [1:0] parityMode;
	logic [DIV_W-1:0] divisor;
	logic [31:0] readMux;
	ump_rx_entry_t head, waitEntry, newEntry;
	logic [8:0] txHold;
	logic [9:0] rxShift;
	logic [12:0] txShift, txFrame;
	logic [4:0] samp, curSamp, perBit, firstVote;
	logic [3:0] rxIdx, rxBits, txLeft, txLen;
	ump_rx_state_t rxState;
	ump_tx_state_t txState;

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
		end else begin
			rxMeta <= serial_in_pin;
			rxSync <= rxMeta;
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign access = psel && penable && !pready;
	assign mapped = (paddr == UMP_ADDR_CTRL_STATUS_A) || (paddr == UMP_ADDR_DATA_BUFFER) ||
		(paddr == UMP_ADDR_CTRL_B) || (paddr == UMP_ADDR_BAUD);
	assign dataRead = access && !pwrite && (paddr == UMP_ADDR_DATA_BUFFER);
	assign dataWrite = access && pwrite && (paddr == UMP_ADDR_DATA_BUFFER);
	assign ctrlWrite = access && pwrite && (paddr == UMP_ADDR_CTRL_STATUS_A);

	always_comb begin
		readMux = 32'h00000000;
		case (paddr)
			UMP_ADDR_CTRL_STATUS_A: begin
				readMux[7:0] = {headValid, txCompleteFlag, !txBufFull,
					headValid && head.frameErr, overrunFlag,
					headValid && head.parityErr, doubleSpeed, filterEn};
			end
			UMP_ADDR_DATA_BUFFER: readMux[7:0] = headValid ? head.data : 8'h00;
			UMP_ADDR_CTRL_B: begin
				readMux[UMP_BIT_RXEN] = rxEnable;
				readMux[UMP_BIT_TXEN] = txEnable;
				readMux[UMP_POS_CSIZE +: 3] = charSizeSel;
				readMux[UMP_POS_PARITY +: 2] = parityMode;
				readMux[UMP_BIT_STOP2] = stopBitsSel;
				readMux[UMP_BIT_RX9] = headValid && head.ninth;
				readMux[UMP_BIT_TX9] = txNinth;
			end
			UMP_ADDR_BAUD: readMux[DIV_W-1:0] = divisor;
			default: readMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			if (access) begin
				prdata <= pwrite ? 32'h00000000 : readMux;
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			filterEn <= UMP_RST_CTRL_STATUS_A[UMP_BIT_FILTER];
			doubleSpeed <= UMP_RST_CTRL_STATUS_A[UMP_BIT_DOUBLE];
			rxEnable <= 1'b0;
			txEnable <= 1'b0;
			charSizeSel <= UMP_RST_CSIZE;
			parityMode <= 2'h0;
			stopBitsSel <= 1'b0;
			txNinth <= 1'b0;
			divisor <= DIV_W'(UMP_RST_DIVISOR);
		end else if (access && pwrite) begin
			if (paddr == UMP_ADDR_CTRL_STATUS_A) begin
				filterEn <= pwdata[UMP_BIT_FILTER];
				doubleSpeed <= pwdata[UMP_BIT_DOUBLE];
			end
			if (paddr == UMP_ADDR_CTRL_B) begin
				rxEnable <= pwdata[UMP_BIT_RXEN];
				txEnable <= pwdata[UMP_BIT_TXEN];
				charSizeSel <= pwdata[UMP_POS_CSIZE +: 3];
				parityMode <= pwdata[UMP_POS_PARITY +: 2];
				stopBitsSel <= pwdata[UMP_BIT_STOP2];
				txNinth <= pwdata[UMP_BIT_TX9];
			end
			if (paddr == UMP_ADDR_BAUD) divisor <= pwdata[DIV_W-1:0];
		end
	end

	ump_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.divisor(divisor),
		.doubleSpeed(doubleSpeed),
		.sampleTick(sampleTick),
		.bitTick(bitTick)
	);

	// ----------------------------------------
	// receiver sampling and frame classification
	// ----------------------------------------
	assign perBit = doubleSpeed ? UMP_SAMPLES_DOUBLE : UMP_SAMPLES_NORMAL;
	assign firstVote = doubleSpeed ? UMP_VOTE_DOUBLE : UMP_VOTE_NORMAL;
	assign curSamp = (samp >= perBit) ? 5'h01 : samp + 5'h01;
	assign vote = (v0 & v1) | (v0 & rxSync) | (v1 & rxSync);
	assign rxBits = charBits(charSizeSel);
	assign parityOn = parityMode[1];
	assign startSeen = sampleTick && (rxState == RX_IDLE) && rxPrev && !rxSync;
	assign stopDecide = sampleTick && (rxState == RX_STOP) && (curSamp == firstVote + 5'h02);

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !rxEnable) begin
			rxState <= RX_IDLE;
			rxPrev <= 1'b1;
			samp <= '0;
			v0 <= 1'b1;
			v1 <= 1'b1;
			rxIdx <= '0;
			rxShift <= '0;
		end else if (sampleTick) begin
			rxPrev <= rxSync;
			case (rxState)
				RX_IDLE: begin
					if (rxPrev && !rxSync) begin
						rxState <= RX_START;
						samp <= 5'h01;
						rxIdx <= '0;
						rxShift <= '0;
					end
				end
				default: begin
					samp <= curSamp;
					if (curSamp == firstVote) v0 <= rxSync;
					if (curSamp == firstVote + 5'h01) v1 <= rxSync;
					if (curSamp == firstVote + 5'h02) begin
						case (rxState)
							RX_START: rxState <= vote ? RX_IDLE : RX_DATA;
							RX_DATA: begin
								rxShift[rxIdx] <= vote;
								if (rxIdx == rxBits + 4'(parityOn) - 4'h1) rxState <= RX_STOP;
								rxIdx <= rxIdx + 4'h1;
							end
							default: rxState <= RX_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	always_comb begin
		newEntry.data = 8'(rxShift[8:0] & charMask(charSizeSel));
		newEntry.ninth = (charSizeSel == UMP_CSIZE_NINE) && rxShift[8];
		newEntry.frameErr = !vote;
		newEntry.parityErr = parityOn &&
			((^(rxShift[8:0] & charMask(charSizeSel))) ^ parityMode[0] ^ rxShift[rxBits]);
		frameType = (charSizeSel == UMP_CSIZE_NINE) ? rxShift[8] : vote;
	end

	assign fifoPush = waitValid && !fifoFull;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !rxEnable) begin
			waitValid <= 1'b0;
			waitEntry <= '0;
		end else if (stopDecide && (!filterEn || frameType)) begin
			waitValid <= 1'b1;
			waitEntry <= newEntry;
		end else if (fifoPush) waitValid <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !rxEnable) begin
			overrunFlag <= 1'b0;
		end else if (startSeen && fifoFull && waitValid) begin
			overrunFlag <= 1'b1;
		end else if (dataRead) begin
			overrunFlag <= 1'b0;
		end
	end

	ump_rx_fifo #(
		.WIDTH($bits(ump_rx_entry_t)),
		.DEPTH(UMP_RX_DEPTH)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.flush(!rxEnable),
		.push(fifoPush),
		.pushData(waitEntry),
		.pop(dataRead),
		.headData(head),
		.headValid(headValid),
		.full(fifoFull)
	);

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	always_comb begin
		txFrame = '1;
		txFrame[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < rxBits) txFrame[i + 1] = txHold[i];
		end
		if (parityOn) begin
			txFrame[rxBits + 4'h1] = (^(txHold & charMask(charSizeSel))) ^ parityMode[0];
		end
		txLen = 4'h2 + rxBits + 4'(parityOn) + 4'(stopBitsSel);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			txBufFull <= 1'b0;
			txHold <= '0;
		end else if (dataWrite && !txBufFull) begin
			txBufFull <= 1'b1;
			txHold <= {txNinth, pwdata[7:0]};
		end else if (txEnable && txBufFull && (txState == TX_IDLE || (bitTick && txLeft == '0))) begin
			txBufFull <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			txState <= TX_IDLE;
			txShift <= '1;
			txLeft <= '0;
			serial_out_pin <= 1'b1;
		end else begin
			case (txState)
				TX_IDLE: begin
					if (txEnable && txBufFull) begin
						txState <= TX_SHIFT;
						txShift <= txFrame;
						txLeft <= txLen;
					end
				end
				default: begin
					if (bitTick) begin
						if (txLeft == '0) begin
							txShift <= txFrame;
							txLeft <= txLen;
							txState <= (txEnable && txBufFull) ? TX_SHIFT : TX_IDLE;
						end else begin
							serial_out_pin <= txShift[0];
							txShift <= {1'b1, txShift[12:1]};
							txLeft <= txLeft - 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			txCompleteFlag <= UMP_RST_CTRL_STATUS_A[UMP_BIT_TXC];
		end else if (txState == TX_SHIFT && bitTick && txLeft == '0 && !txBufFull) begin
			txCompleteFlag <= 1'b1;
		end else if (txCompleteAck || (ctrlWrite && pwdata[UMP_BIT_TXC])) begin
			txCompleteFlag <= 1'b0;
		end
	end

	// ----------------------------------------
	// request outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rxCompleteReq <= 1'b0;
			txCompleteReq <= 1'b0;
			txEmptyReq <= 1'b0;
		end else begin
			rxCompleteReq <= headValid;
			txCompleteReq <= txCompleteFlag;
			txEmptyReq <= !txBufFull;
		end
	end

endmodule

// ===== test/ump_serial_chk.sv
// assertions on the apb, serial and request ports of the serial port
// assumes the bind below onto ump_serial, one clock domain
`timescale 1ns/100ps
module ump_serial_chk import ump_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic txCompleteAck,
	input wire logic rxCompleteReq,
	input wire logic txCompleteReq,
	input wire logic txEmptyReq
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic taken;
	logic mapped;
	assign taken = psel && penable && !pready;
	assign mapped = paddr inside {UMP_ADDR_CTRL_STATUS_A, UMP_ADDR_DATA_BUFFER,
		UMP_ADDR_CTRL_B, UMP_ADDR_BAUD};
	chk_ready_after_access: assert property (taken |=> pready)
		else $error("pready missing after access");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_unmapped_err: assert property (taken && !mapped |=> pslverr)
		else $error("no error on unmapped address");
	chk_mapped_no_err: assert property (taken && mapped |=> !pslverr)
		else $error("error on mapped address");
	chk_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer not zero");
	chk_empty_after_reset: assert property ($rose(rst_n) |-> ##[1:3] txEmptyReq)
		else $error("buffer empty not set after reset");
	chk_ack_clears_txc: assert property (txCompleteAck |-> ##[1:3] !txCompleteReq)
		else $error("transmit complete not cleared by ack");
	chk_start_bit_len: assert property ($fell(serial_out_pin) |-> ##1 !serial_out_pin[*7])
		else $error("start bit too short");
	chk_write_starts_tx: assert property (taken && pwrite && paddr == UMP_ADDR_DATA_BUFFER
		&& txEmptyReq |-> ##[1:400] !serial_out_pin)
		else $error("written data never sent");
	cover property (taken && !pwrite && paddr == UMP_ADDR_DATA_BUFFER);
	cover property (pslverr);
	cover property ($rose(txCompleteReq));
endmodule

bind ump_serial ump_serial_chk ump_serial_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin), .txCompleteAck(txCompleteAck),
	.rxCompleteReq(rxCompleteReq), .txCompleteReq(txCompleteReq), .txEmptyReq(txEmptyReq));

// ===== test/ump_node_model.sv
// far serial node: sends frames into the port and captures frames from it
// assumes the bench's clk_sys; the line idles high between frames
`timescale 1ns/100ps
module ump_node_model (
	input wire logic clk_sys,
	input wire logic rxLine,
	output logic txLine
);
	// ----------------------------------------
	// frame tasks
	// ----------------------------------------
	initial txLine = 1'b1;
	// bits after start go lsb first; the idle tail doubles as the second stop bit
	task automatic send_bits(input logic [11:0] bits, input int n, input int bitLen);
		@(posedge clk_sys);
		txLine <= 1'b0;
		repeat (bitLen) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			txLine <= bits[i];
			repeat (bitLen) @(posedge clk_sys);
		end
		txLine <= 1'b1;
		repeat (2 * bitLen) @(posedge clk_sys);
	endtask
	// samples mid-bit; returns at the middle of the last bit asked for
	task automatic recv_bits(input int n, input int bitLen, output logic [11:0] bits,
		output logic seen);
		int t;
		bits = 12'h000;
		seen = 1'b0;
		for (t = 0; t < 600 && rxLine !== 1'b0; t++) @(posedge clk_sys);
		if (rxLine === 1'b0) begin
			seen = 1'b1;
			repeat (bitLen / 2) @(posedge clk_sys);
			for (int i = 0; i < n; i++) begin
				repeat (bitLen) @(posedge clk_sys);
				bits[i] = rxLine;
			end
		end
	endtask
endmodule

// ===== test/ump_serial_test.sv
// self-checking bench of the multi-processor serial port
// assumes ump_serial with its bound checker and the node model on the line
`timescale 1ns/100ps
module ump_serial_test import ump_pkg::*; ;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, txCompleteAck = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rxIn, txOut, rxReq, txReq, emptyReq;
	int n_mismatch = 0, n_tests = 0, bl = 16;
	localparam logic [7:0] A = UMP_ADDR_CTRL_STATUS_A, D = UMP_ADDR_DATA_BUFFER;
	localparam logic [7:0] B = UMP_ADDR_CTRL_B;
	ump_serial ump_serial_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_in_pin(rxIn), .serial_out_pin(txOut),
		.txCompleteAck(txCompleteAck), .rxCompleteReq(rxReq), .txCompleteReq(txReq),
		.txEmptyReq(emptyReq));
	ump_node_model ump_node_model_inst (.clk_sys(clk_sys), .rxLine(txOut), .txLine(rxIn));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (pready !== 1'b1 && t < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
		if (t >= 50) begin
			n_mismatch++;
			final_report();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp(q, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic send(input logic [11:0] b, input int n);
		ump_node_model_inst.send_bits(b, n, bl);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		logic [11:0] g1, g2;
		logic s1, s2;
		logic [31:0] q;
		logic e;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(A, 32'h20);
		cmp({31'h0, emptyReq}, 32'h1);
		rd(B, 32'h0c);
		apb(1'b0, 8'hd0, 32'h0, q, e);
		cmp({31'h0, e}, 32'h1);
		wr(UMP_ADDR_BAUD, 32'h0);
		wr(B, 32'h1f);
		wr(A, 32'h01);
		send(12'h233, 10);
		send(12'h35a, 10);
		rd(A, 32'ha1);
		cmp({31'h0, rxReq}, 32'h1);
		rd(B, 32'h11f);
		rd(D, 32'h5a);
		rd(A, 32'h21);
		wr(A, 32'h0);
		send(12'h233, 10);
		rd(B, 32'h1f);
		rd(D, 32'h33);
		wr(B, 32'h0f);
		wr(A, 32'h01);
		send(12'h044, 9);
		send(12'h1c7, 9);
		rd(A, 32'ha1);
		rd(D, 32'hc7);
		wr(A, 32'h0);
		wr(B, 32'h03);
		send(12'h035, 6);
		rd(D, 32'h15);
		wr(B, 32'h0f);
		send(12'h0a5, 9);
		rd(A, 32'hb0);
		rd(D, 32'ha5);
		rd(A, 32'h20);
		wr(B, 32'h4f);
		send(12'h301, 10);
		send(12'h201, 10);
		rd(A, 32'ha0);
		rd(D, 32'h01);
		rd(A, 32'ha4);
		rd(D, 32'h01);
		wr(B, 32'h0f);
		for (int i = 0; i < 4; i++)
			send(12'h100 + 12'(i), 9);
		rd(A, 32'ha8);
		rd(D, 32'h00);
		wr(B, 32'h0e);
		rd(A, 32'h20);
		cmp({31'h0, rxReq}, 32'h0);
		wr(B, 32'h0f);
		wr(A, 32'h02);
		bl = 8;
		send(12'h15a, 9);
		rd(D, 32'h5a);
		bl = 16;
		wr(A, 32'h01);
		fork
			ump_node_model_inst.recv_bits(9, bl, g1, s1);
			wr(D, 32'h1a5);
		join
		cmp({20'h0, g1}, 32'h1a5);
		repeat (40) @(posedge clk_sys);
		rd(A, 32'h61);
		cmp({31'h0, txReq}, 32'h1);
		txCompleteAck <= 1'b1;
		@(posedge clk_sys);
		txCompleteAck <= 1'b0;
		rd(A, 32'h21);
		fork
			begin
				ump_node_model_inst.recv_bits(9, bl, g1, s1);
				ump_node_model_inst.recv_bits(9, bl, g2, s2);
				cmp({20'h0, g1}, 32'h111);
				cmp({20'h0, g2}, 32'h122);
				ump_node_model_inst.recv_bits(9, bl, g1, s1);
				cmp({31'h0, s1}, 32'h0);
			end
			begin
				wr(D, 32'h11);
				wr(D, 32'h22);
				wr(D, 32'h33);
			end
		join
		rd(A, 32'h61);
		wr(A, 32'h41);
		rd(A, 32'h21);
		wr(B, 32'h03);
		fork
			ump_node_model_inst.recv_bits(6, bl, g1, s1);
			wr(D, 32'hdf);
		join
		cmp({20'h0, g1}, 32'h3f);
		final_report();
	end
endmodule
